/* dpr_dma_model.sv */
// DMA-side master model driving the second RAM port
`timescale 1ns/10ps
module dpr_dma_model (
  input  wire logic        clock,
  input  wire logic [34:0] cmd,
  output logic             dma_req = 1'b0,
  output logic             dma_we = 1'b0,
  output logic             dma_byte = 1'b0,
  output logic [15:0]      dma_addr = '0,
  output logic [15:0]      dma_wdata = '0
);
  // Lines flip while idle so stale values never read as fresh
  always @(negedge clock) begin
    {dma_req, dma_we, dma_byte} <= cmd[34:32];
    {dma_addr, dma_wdata} <= cmd[34] ? cmd[31:0] : ~{dma_addr, dma_wdata};
  end
endmodule : dpr_dma_model

/* dpr_pkg.sv */
// Constants for the dual-port shared data RAM
// Operation
// [R1] 2-Kbyte dual-port RAM at top of data space
// [R2] CPU and DMA accesses served in same cycle
// [R3] DMA traffic never takes CPU cycles
// [R4] CPU wins same-location simultaneous writes
// [R5] Collisions never stall the CPU port
// [R6] CPU may use RAM as general storage
// [R7] 16-bit words, byte lane picked by LSb
// [R8] Byte read returns selected byte on low lane
// [R9] Colliding DMA write data is discarded
package dpr_pkg;
  localparam int unsigned RAM_BYTES   = 2048;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned WORDS       = RAM_BYTES / 2;
  localparam int unsigned WIDX_W      = $clog2(WORDS);
  // RAM sits at the top end of the 32-Kbyte implemented data space
  localparam logic [ADDR_W-1:0] BASE_ADDR = 16'h7800;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 16'h7FFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam int unsigned LSB_BIT     = 0;
  // Word index starts just above the byte-select bit
  localparam int unsigned WORD_LSB    = 1;
  localparam int unsigned LANES       = 2;
  localparam logic [1:0] LANE_NONE    = 2'h0;
  localparam logic [1:0] LANE_LO      = 2'h1;
  localparam logic [1:0] LANE_HI      = 2'h2;
  localparam logic [1:0] LANE_BOTH    = 2'h3;
endpackage : dpr_pkg

/* dpr_port.sv */
// One access port: decode, byte-lane enables and read-data steering
`timescale 1ns/10ps
module dpr_port (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          req,
  input  wire logic                          we,
  input  wire logic                          byte_mode,
  input  wire logic [dpr_pkg::ADDR_W-1:0]    addr,
  input  wire logic [dpr_pkg::DATA_W-1:0]    wdata,
  input  wire logic [dpr_pkg::DATA_W-1:0]    word_q,
  output logic                               hit,
  output logic [dpr_pkg::WIDX_W-1:0]         widx,
  output logic [1:0]                         lane_we,
  output logic [dpr_pkg::DATA_W-1:0]         wword,
  output logic [dpr_pkg::DATA_W-1:0]         rdata,
  output logic                               rvalid
);
  logic sel_hi;
  logic rd_byte;
  logic rd_hi;
  logic rd_hit;
  logic rd_pend;

  // Address decode; outside the window the port reads zero
  assign hit = req && (addr >= dpr_pkg::BASE_ADDR) &&
               (addr <= dpr_pkg::LAST_ADDR); // R1
  assign widx = addr[dpr_pkg::WIDX_W+dpr_pkg::WORD_LSB-1:dpr_pkg::WORD_LSB];
  assign sel_hi = addr[dpr_pkg::LSB_BIT];

  // Byte writes replicate data on both lanes, enable only one
  always_comb begin
    lane_we = dpr_pkg::LANE_NONE;
    wword = wdata;
    if (hit && we) begin
      if (byte_mode) begin
        lane_we = sel_hi ? dpr_pkg::LANE_HI : dpr_pkg::LANE_LO; // R7
        wword = {wdata[dpr_pkg::BYTE_W-1:0], wdata[dpr_pkg::BYTE_W-1:0]};
      end else begin
        lane_we = dpr_pkg::LANE_BOTH;
      end
    end
  end

  // Remember read shape for the cycle the word arrives
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend <= 1'h0;
      rd_byte <= 1'h0;
      rd_hi <= 1'h0;
      rd_hit <= 1'h0;
    end else begin
      rd_pend <= req && !we;
      rd_byte <= byte_mode;
      rd_hi <= sel_hi;
      rd_hit <= hit;
    end
  end

  assign rvalid = rd_pend;

  // Whole word fetched, chosen byte moved to the low lane
  always_comb begin
    if (!rd_hit) begin
      rdata = dpr_pkg::ZERO_WORD;
    end else if (rd_byte) begin
      rdata = {dpr_pkg::ZERO_BYTE, rd_hi ?
               word_q[dpr_pkg::DATA_W-1:dpr_pkg::BYTE_W] :
               word_q[dpr_pkg::BYTE_W-1:0]}; // R8
    end else begin
      rdata = word_q;
    end
  end
endmodule : dpr_port

/* dpr_ram.sv */
// Dual-port shared RAM top: CPU port and DMA port, CPU wins collisions
`timescale 1ns/10ps
module dpr_ram (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          cpu_req,
  input  wire logic                          cpu_we,
  input  wire logic                          cpu_byte,
  input  wire logic [dpr_pkg::ADDR_W-1:0]    cpu_addr,
  input  wire logic [dpr_pkg::DATA_W-1:0]    cpu_wdata,
  output logic [dpr_pkg::DATA_W-1:0]         cpu_rdata,
  output logic                               cpu_rvalid,
  output logic                               cpu_ready,
  input  wire logic                          dma_req,
  input  wire logic                          dma_we,
  input  wire logic                          dma_byte,
  input  wire logic [dpr_pkg::ADDR_W-1:0]    dma_addr,
  input  wire logic [dpr_pkg::DATA_W-1:0]    dma_wdata,
  output logic [dpr_pkg::DATA_W-1:0]         dma_rdata,
  output logic                               dma_rvalid,
  output logic                               dma_ready,
  output logic                               dma_collide
);
  logic [dpr_pkg::DATA_W-1:0] mem [dpr_pkg::WORDS];
  logic [dpr_pkg::DATA_W-1:0] cpu_q;
  logic [dpr_pkg::DATA_W-1:0] dma_q;
  logic                       cpu_hit;
  logic                       dma_hit;
  logic [dpr_pkg::WIDX_W-1:0] cpu_widx;
  logic [dpr_pkg::WIDX_W-1:0] dma_widx;
  logic [1:0]                 cpu_lwe;
  logic [1:0]                 dma_lwe;
  logic [1:0]                 dma_lwe_eff;
  logic [dpr_pkg::DATA_W-1:0] cpu_wword;
  logic [dpr_pkg::DATA_W-1:0] dma_wword;
  logic                       same_word;

  dpr_port u_cpu (
    .clock   (clock),
    .rst_b   (rst_b),
    .req     (cpu_req),
    .we      (cpu_we),
    .byte_mode (cpu_byte),
    .addr    (cpu_addr),
    .wdata   (cpu_wdata),
    .word_q  (cpu_q),
    .hit     (cpu_hit),
    .widx    (cpu_widx),
    .lane_we (cpu_lwe),
    .wword   (cpu_wword),
    .rdata   (cpu_rdata),
    .rvalid  (cpu_rvalid)
  );

  dpr_port u_dma (
    .clock   (clock),
    .rst_b   (rst_b),
    .req     (dma_req),
    .we      (dma_we),
    .byte_mode (dma_byte),
    .addr    (dma_addr),
    .wdata   (dma_wdata),
    .word_q  (dma_q),
    .hit     (dma_hit),
    .widx    (dma_widx),
    .lane_we (dma_lwe),
    .wword   (dma_wword),
    .rdata   (dma_rdata),
    .rvalid  (dma_rvalid)
  );

  // Both ports always accepted; no arbitration stall on either side
  assign cpu_ready = 1'h1; // R3 R5 R6
  assign dma_ready = 1'h1; // R2

  // Per-lane masking: a DMA lane that overlaps a CPU lane is dropped,
  // so a CPU byte write only blocks the DMA byte it shares
  assign same_word = cpu_hit && dma_hit && (cpu_widx == dma_widx);
  assign dma_lwe_eff = same_word ? (dma_lwe & ~cpu_lwe) : dma_lwe; // R4 R9
  assign dma_collide = same_word && |(dma_lwe & cpu_lwe);

  // Array write and read, both ports every cycle; contents not reset
  always_ff @(posedge clock) begin
    for (int l = 0; l < dpr_pkg::LANES; l++) begin
      if (cpu_lwe[l]) begin
        mem[cpu_widx][l*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W] <=
          cpu_wword[l*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W]; // R2 R7
      end
      if (dma_lwe_eff[l]) begin
        mem[dma_widx][l*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W] <=
          dma_wword[l*dpr_pkg::BYTE_W +: dpr_pkg::BYTE_W]; // R4
      end
    end
    cpu_q <= mem[cpu_widx]; // R1
    dma_q <= mem[dma_widx];
  end
endmodule : dpr_ram

/* dpr_ram_properties.sv */
// Port-level assertions for the dual-port shared RAM
`timescale 1ns/10ps
module dpr_ram_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        cpu_req,
  input wire logic        cpu_we,
  input wire logic        cpu_byte,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_rdata,
  input wire logic        cpu_rvalid,
  input wire logic        cpu_ready,
  input wire logic        dma_req,
  input wire logic        dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic        dma_ready,
  input wire logic        dma_collide
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // A CPU read, and both ports writing in one cycle
  sequence s_cpu_rd; cpu_req && !cpu_we; endsequence
  sequence s_both_wr; cpu_req && cpu_we && dma_req && dma_we; endsequence
  a_cpu_no_stall: assert property (cpu_ready)
    else $error("cpu stalled");
  a_dma_no_stall: assert property (dma_ready)
    else $error("dma stalled");
  a_cpu_rd_answer: assert property (s_cpu_rd |=> cpu_rvalid)
    else $error("cpu read unanswered");
  a_cpu_no_spur: assert property (!(cpu_req && !cpu_we) |=> !cpu_rvalid)
    else $error("cpu spurious valid");
  a_byte_low_lane: assert property (s_cpu_rd ##0 cpu_byte
    |=> cpu_rdata[15:8] == 8'h00)
    else $error("byte read upper lane");
  a_range_zero: assert property (s_cpu_rd ##0 cpu_addr[15:11] != 5'h0F
    |=> cpu_rdata == 16'h0000)
    else $error("outside read not zero");
  a_collide_cause: assert property (dma_collide |-> s_both_wr
    ##0 cpu_addr[10:1] == dma_addr[10:1])
    else $error("collide without cause");
  a_collide_word: assert property (s_both_wr ##0 !cpu_byte ##0
    cpu_addr == dma_addr ##0 cpu_addr[15:11] == 5'h0F |-> dma_collide)
    else $error("collision missed");
endmodule : dpr_ram_properties
bind dpr_ram dpr_ram_properties u_props (
  .clock       (clock),
  .rst_b       (rst_b),
  .cpu_req     (cpu_req),
  .cpu_we      (cpu_we),
  .cpu_byte    (cpu_byte),
  .cpu_addr    (cpu_addr),
  .cpu_rdata   (cpu_rdata),
  .cpu_rvalid  (cpu_rvalid),
  .cpu_ready   (cpu_ready),
  .dma_req     (dma_req),
  .dma_we      (dma_we),
  .dma_addr    (dma_addr),
  .dma_ready   (dma_ready),
  .dma_collide (dma_collide)
);

/* dpr_ram_tb.sv */
// Self-checking bench for the dual-port shared RAM
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  errors++; $display("Error %s exp %h got %h", n, e, s); end end
module dpr_ram_tb;
  logic        clock = 0, rst_b = 0, cpu_req = 0, cpu_we = 0, cpu_byte = 0;
  logic        dma_req, dma_we, dma_byte, dma_collide;
  logic        cpu_rvalid, cpu_ready, dma_rvalid, dma_ready;
  logic [15:0] cpu_addr = '0, cpu_wdata = '0, cpu_rdata, dma_rdata;
  logic [15:0] dma_addr, dma_wdata;
  logic [34:0] cmd = '0;
  int          errors = 0, checks_done = 0;
  // Rows: write, byte, address, data or expected read
  logic [33:0] rows [9] = '{{2'b10, 32'h7800A55A}, {2'b11, 32'h780100C3},
    {2'b00, 32'h7800C35A}, {2'b01, 32'h780100C3}, {2'b01, 32'h7800005A},
    {2'b10, 32'h7FFF1234}, {2'b00, 32'h7FFE1234}, {2'b10, 32'h0100BEEF},
    {2'b00, 32'h01000000}};
  dpr_ram dut (
    .clock       (clock),
    .rst_b       (rst_b),
    .cpu_req     (cpu_req),
    .cpu_we      (cpu_we),
    .cpu_byte    (cpu_byte),
    .cpu_addr    (cpu_addr),
    .cpu_wdata   (cpu_wdata),
    .cpu_rdata   (cpu_rdata),
    .cpu_rvalid  (cpu_rvalid),
    .cpu_ready   (cpu_ready),
    .dma_req     (dma_req),
    .dma_we      (dma_we),
    .dma_byte    (dma_byte),
    .dma_addr    (dma_addr),
    .dma_wdata   (dma_wdata),
    .dma_rdata   (dma_rdata),
    .dma_rvalid  (dma_rvalid),
    .dma_ready   (dma_ready),
    .dma_collide (dma_collide)
  );
  dpr_dma_model u_dma (
    .clock     (clock),
    .cmd       (cmd),
    .dma_req   (dma_req),
    .dma_we    (dma_we),
    .dma_byte  (dma_byte),
    .dma_addr  (dma_addr),
    .dma_wdata (dma_wdata)
  );
  always #5 clock = ~clock;
  task automatic complete_run;
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic drive(input logic [33:0] r);
    @(negedge clock);
    {cpu_req, cpu_we, cpu_byte, cpu_addr, cpu_wdata} = {1'b1, r};
  endtask : drive
  // Release flips the data lines, then checks the one-cycle answer
  task automatic fin(input logic [33:0] r);
    @(negedge clock);
    {cpu_req, cpu_wdata} = {1'b0, ~cpu_wdata};
    `CHK("cpu_rvalid", !r[33], cpu_rvalid)
    if (!r[33]) `CHK("cpu_rdata", r[15:0], cpu_rdata)
  endtask : fin
  // Hang guard
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clock);
    `CHK("rst_rvalid", 1'b0, cpu_rvalid)
    @(negedge clock) rst_b = 1'b1;
    foreach (rows[i]) begin
      drive(rows[i]);
      fin(rows[i]);
    end
    // Same word written by both ports: the CPU value stays
    @(posedge clock) cmd <= {3'b110, 32'h78102222};
    drive({2'b10, 32'h78101111});
    cmd[34] <= 1'b0;
    #1 `CHK("collide", 1'b1, dma_collide)
    fin({2'b10, 32'h0});
    drive({2'b00, 32'h78101111});
    fin({2'b00, 32'h78101111});
    // Different lanes of one word: both bytes land
    @(posedge clock) cmd <= {3'b111, 32'h782000CD};
    drive({2'b11, 32'h782100AB});
    cmd[34] <= 1'b0;
    #1 `CHK("no_collide", 1'b0, dma_collide)
    fin({2'b10, 32'h0});
    // Both ports read in one cycle
    @(posedge clock) cmd <= {3'b100, 32'h78100000};
    drive({2'b00, 32'h7820ABCD});
    cmd[34] <= 1'b0;
    fin({2'b00, 32'h7820ABCD});
    `CHK("dma_rdata", 16'h1111, dma_rdata)
    `CHK("dma_rvalid", 1'h1, dma_rvalid)
    // Mid-run reset while an answer stands: read path clears at once,
    // stored words survive because the array has no reset
    rst_b = 1'h0;
    #1 `CHK("rst_rdata", 16'h0000, cpu_rdata)
    `CHK("rst_rvalid_mid", 1'h0, cpu_rvalid)
    @(negedge clock) rst_b = 1'h1;
    drive({2'b00, 32'h7820ABCD});
    fin({2'b00, 32'h7820ABCD});
    complete_run;
  end
endmodule : dpr_ram_tb
